// ===== src/sepp_params.svh
`ifndef SEPP_PARAMS_SVH
`define SEPP_PARAMS_SVH
// core clock rate, standing in for the on-chip write oscillator
`define SEPP_CLK_MHZ 200
// self-timed phase lengths
`define SEPP_ERASE_TIME_US 1000
`define SEPP_PROG_TIME_US 1000
`define SEPP_ERASE_CYC (`SEPP_ERASE_TIME_US * `SEPP_CLK_MHZ)
`define SEPP_PROG_CYC (`SEPP_PROG_TIME_US * `SEPP_CLK_MHZ)
// frame bit counts after the start bit
`define SEPP_CNT_W 5
`define SEPP_FRAME_W 19
`define SEPP_LEN_SHORT 5'h0b
`define SEPP_LEN_LONG 5'h13
// instruction codes
`define SEPP_OP_EXT 2'h0
`define SEPP_OP_WRITE 2'h1
`define SEPP_OP_ERASE 2'h3
`define SEPP_SUB_EN 2'h3
`define SEPP_SUB_DIS 2'h0
`define SEPP_SUB_BULK_ERASE_CMD 2'h2
`define SEPP_SUB_BULK_FILL_CMD 2'h1
// field positions, long frame then short frame
`define SEPP_L_OP_HI 18
`define SEPP_L_OP_LO 17
`define SEPP_L_SUB_HI 16
`define SEPP_L_SUB_LO 15
`define SEPP_L_ADDR_HI 15
`define SEPP_L_ADDR_LO 8
`define SEPP_S_OP_HI 10
`define SEPP_S_OP_LO 9
`define SEPP_S_SUB_HI 8
`define SEPP_S_SUB_LO 7
// erased byte value
`define SEPP_ERASED 8'hff
`endif

// ===== src/sepp_pkg.sv
package sepp_pkg;
  typedef enum logic [2:0] {k_none, k_write, k_erase, k_en, k_dis, k_bulk_erase_cmd, k_bulk_fill_cmd} sepp_kind_t;
  typedef enum logic [1:0] {wc_idle, wc_erase, wc_prog} sepp_wc_state_t;
endpackage

// ===== src/sepp_wcycle.sv
`timescale 1ns/100ps
`default_nettype none
module sepp_wcycle
#(
  parameter int ERASE_CYC = 200000,
  parameter int PROG_CYC = 200000
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // cycle request
  input wire logic start,
  input wire logic two_phase,
  // cycle status
  output logic busy,
  output logic erase_done,
  output logic prog_done
);
  import sepp_pkg::*;

  localparam int MAXC = (ERASE_CYC > PROG_CYC) ? ERASE_CYC : PROG_CYC;
  localparam int CW = $clog2(MAXC + 1);

  sepp_wc_state_t state_ff;
  logic [CW-1:0] cnt_ff;
  logic two_ff;
  logic last;

  assign busy = (state_ff != wc_idle);
  assign last = (state_ff == wc_erase) ? (cnt_ff == CW'(ERASE_CYC - 1))
                                       : (cnt_ff == CW'(PROG_CYC - 1));
  assign erase_done = ce && (state_ff == wc_erase) && last;
  assign prog_done = ce && (state_ff == wc_prog) && last;

  // timed from the core clock only, no serial clock needed
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= wc_idle;
      cnt_ff <= '0;
      two_ff <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_ff)
        wc_idle:
        begin
          cnt_ff <= '0;
          if (start)
          begin
            state_ff <= wc_erase;
            two_ff <= two_phase;
          end
        end
        wc_erase:
        begin
          cnt_ff <= last ? '0 : cnt_ff + 1'b1;
          if (last)
            state_ff <= two_ff ? wc_prog : wc_idle;
        end
        wc_prog:
        begin
          cnt_ff <= last ? '0 : cnt_ff + 1'b1;
          if (last)
            state_ff <= wc_idle;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== src/sepp_engine.sv
// Function
// - write erases then programs addressed byte
// - internal cycle timed by own clock
// - frames ignored while internal cycle runs
// - select high after a cycle starts shows busy low, ready high
// - enable/disable: start, 00, 11/00, seven bits
// - disabled state blocks every write and erase
// - enabled state holds until disable arrives
// - erase-all frame sets every bit one
// - write-all frame fills every location
// - write-all erases old contents itself
// - erase frame sets addressed byte to ones
// - select falling after valid frame starts cycle
// - data in sampled on serial clock rise
// - nine-bit address, first bit ignored
`timescale 1ns/100ps
`default_nettype none
`include "sepp_params.svh"
module sepp_engine
#(
  parameter int ERASE_CYC = `SEPP_ERASE_CYC,
  parameter int PROG_CYC = `SEPP_PROG_CYC,
  parameter int AW = 8,
  parameter int DW = 8
)
(
  // core clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // serial link
  input wire logic serial_clock,
  input wire logic chip_select,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // status
  output logic program_enable,
  output logic busy,
  // stored contents view
  input wire logic [AW-1:0] peek_addr,
  output logic [DW-1:0] peek_data
);
  import sepp_pkg::*;

  localparam int FW = `SEPP_FRAME_W;
  localparam int CNW = `SEPP_CNT_W;

  // ---------------- link domain ----------------
  logic link_rst_n;
  logic started_ff;
  logic stop_ff;
  logic [CNW-1:0] cnt_ff;
  logic [FW-1:0] sh_ff;
  logic [FW-1:0] nxt_sh;
  logic [CNW-1:0] nxt_cnt;
  logic fin;
  logic [FW:0] hold_ff;
  logic tog_ff;

  function automatic logic frame_complete(input logic [FW-1:0] v, input logic [CNW-1:0] n);
    logic [1:0] sop;
    logic [1:0] lop;
    sop = v[`SEPP_S_OP_HI:`SEPP_S_OP_LO];
    lop = v[`SEPP_L_OP_HI:`SEPP_L_OP_LO];
    frame_complete = 1'b0;
    if (n == `SEPP_LEN_SHORT)
      frame_complete = (sop == `SEPP_OP_ERASE) ||
                       ((sop == `SEPP_OP_EXT) &&
                        (v[`SEPP_S_SUB_HI:`SEPP_S_SUB_LO] != `SEPP_SUB_BULK_FILL_CMD));
    else if (n == `SEPP_LEN_LONG)
      frame_complete = (lop == `SEPP_OP_WRITE) ||
                       ((lop == `SEPP_OP_EXT) &&
                        (v[`SEPP_L_SUB_HI:`SEPP_L_SUB_LO] == `SEPP_SUB_BULK_FILL_CMD));
  endfunction

  // select low clears the frame: a partial frame simply vanishes
  assign link_rst_n = arst_n & chip_select;
  assign nxt_sh = {sh_ff[FW-2:0], serial_in};
  assign nxt_cnt = cnt_ff + 1'b1;
  assign fin = started_ff && !stop_ff && frame_complete(nxt_sh, nxt_cnt);

  // bits taken on the rising serial clock edge
  always_ff @(posedge serial_clock or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      started_ff <= 1'b0;
      stop_ff <= 1'b0;
      cnt_ff <= '0;
      sh_ff <= '0;
    end
    else if (!started_ff)
    begin
      started_ff <= serial_in;
    end
    else if (!stop_ff)
    begin
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      stop_ff <= fin || (nxt_cnt == `SEPP_LEN_LONG);
    end
  end

  // finished frame held until the next one completes; toggle marks it
  always_ff @(posedge serial_clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_ff <= '0;
      tog_ff <= 1'b0;
    end
    else if (fin)
    begin
      hold_ff <= {(nxt_cnt == `SEPP_LEN_LONG), nxt_sh};
      tog_ff <= ~tog_ff;
    end
  end

  // ---------------- core domain ----------------
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_s3_ff;
  logic cs_lvl_ff;
  logic tg_s1_ff;
  logic tg_s2_ff;
  logic tg_s3_ff;
  logic tg_seen_ff;
  logic cs_fall;
  logic cs_rise;
  logic frame_new;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_s1_ff <= 1'b0;
      cs_s2_ff <= 1'b0;
      cs_s3_ff <= 1'b0;
      tg_s1_ff <= 1'b0;
      tg_s2_ff <= 1'b0;
      tg_s3_ff <= 1'b0;
    end
    else if (ce)
    begin
      cs_s1_ff <= chip_select;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
      tg_s1_ff <= tog_ff;
      tg_s2_ff <= tg_s1_ff;
      tg_s3_ff <= tg_s2_ff;
    end
  end

  assign cs_fall = cs_lvl_ff && !cs_s2_ff && !cs_s3_ff;
  assign cs_rise = !cs_lvl_ff && cs_s2_ff && cs_s3_ff;
  assign frame_new = (tg_s2_ff == tg_s3_ff) && (tg_s3_ff != tg_seen_ff);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_lvl_ff <= 1'b0;
      tg_seen_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (cs_s2_ff == cs_s3_ff)
        cs_lvl_ff <= cs_s3_ff;
      if (frame_new)
        tg_seen_ff <= tg_s3_ff;
    end
  end

  // frame capture and the decision taken after select falls
  logic [FW:0] cap_ff;
  logic armed_ff;
  logic [1:0] pend_ff;
  logic go;
  sepp_kind_t kind;
  logic kind_prog;
  logic wc_busy;
  logic wc_erase_done;
  logic wc_prog_done;
  logic wc_start;

  function automatic sepp_kind_t decode_kind(input logic [FW:0] f);
    logic [1:0] op;
    logic [1:0] sub;
    op = f[FW] ? f[`SEPP_L_OP_HI:`SEPP_L_OP_LO] : f[`SEPP_S_OP_HI:`SEPP_S_OP_LO];
    sub = f[FW] ? f[`SEPP_L_SUB_HI:`SEPP_L_SUB_LO] : f[`SEPP_S_SUB_HI:`SEPP_S_SUB_LO];
    decode_kind = k_none;
    if (op == `SEPP_OP_WRITE)
      decode_kind = k_write;
    else if (op == `SEPP_OP_ERASE)
      decode_kind = k_erase;
    else if (op == `SEPP_OP_EXT)
    begin
      unique case (sub)
        `SEPP_SUB_EN: decode_kind = k_en;
        `SEPP_SUB_DIS: decode_kind = k_dis;
        `SEPP_SUB_BULK_ERASE_CMD: decode_kind = k_bulk_erase_cmd;
        `SEPP_SUB_BULK_FILL_CMD: decode_kind = k_bulk_fill_cmd;
      endcase
    end
  endfunction

  assign kind = decode_kind(cap_ff);
  assign kind_prog = (kind == k_write) || (kind == k_erase) ||
                     (kind == k_bulk_erase_cmd) || (kind == k_bulk_fill_cmd);
  // decision two cycles after the fall so a just-finished frame is seen
  assign go = ce && pend_ff[1] && armed_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cap_ff <= '0;
      armed_ff <= 1'b0;
      pend_ff <= '0;
    end
    else if (ce)
    begin
      pend_ff <= {pend_ff[0], cs_fall};
      if (frame_new)
        cap_ff <= hold_ff;
      if (frame_new)
        armed_ff <= 1'b1;
      else if (go || cs_rise)
        armed_ff <= 1'b0;
    end
  end

  // erase/write enable state
  logic prog_en_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prog_en_ff <= 1'b0;
    else if (go && !wc_busy)
    begin
      if (kind == k_en)
        prog_en_ff <= 1'b1;
      else if (kind == k_dis)
        prog_en_ff <= 1'b0;
    end
  end

  assign program_enable = prog_en_ff;

  // target of the internal cycle
  logic [AW-1:0] tgt_addr_ff;
  logic [DW-1:0] tgt_data_ff;
  logic all_ff;

  assign wc_start = go && !wc_busy && prog_en_ff && kind_prog;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tgt_addr_ff <= '0;
      tgt_data_ff <= '0;
      all_ff <= 1'b0;
    end
    else if (wc_start)
    begin
      // leading address bit is ignored
      tgt_addr_ff <= (kind == k_write) ? cap_ff[`SEPP_L_ADDR_HI:`SEPP_L_ADDR_LO]
                                       : cap_ff[AW-1:0];
      tgt_data_ff <= cap_ff[DW-1:0];
      all_ff <= (kind == k_bulk_erase_cmd) || (kind == k_bulk_fill_cmd);
    end
  end

  sepp_wcycle #(
    .ERASE_CYC(ERASE_CYC),
    .PROG_CYC(PROG_CYC)
  ) u_wcycle (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .start(wc_start),
    .two_phase((kind == k_write) || (kind == k_bulk_fill_cmd)),
    .busy(wc_busy),
    .erase_done(wc_erase_done),
    .prog_done(wc_prog_done)
  );

  assign busy = wc_busy;

  // array: erase sets ones, programming can only clear bits
  logic [DW-1:0] mem_ff [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (wc_erase_done)
    begin
      if (all_ff)
      begin
        for (int i = 0; i < (1 << AW); i++)
          mem_ff[i] <= `SEPP_ERASED;
      end
      else
        mem_ff[tgt_addr_ff] <= `SEPP_ERASED;
    end
    else if (wc_prog_done)
    begin
      if (all_ff)
      begin
        for (int i = 0; i < (1 << AW); i++)
          mem_ff[i] <= mem_ff[i] & tgt_data_ff;
      end
      else
        mem_ff[tgt_addr_ff] <= mem_ff[tgt_addr_ff] & tgt_data_ff;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      peek_data <= '0;
    else if (ce)
      peek_data <= mem_ff[peek_addr];
  end

  // ready/busy shown on data out while select is high after a cycle
  logic status_ff;
  logic so_ff;
  logic so_oe_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_ff <= 1'b0;
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (wc_start)
        status_ff <= 1'b1;
      else if (cs_fall && !wc_busy)
        status_ff <= 1'b0;
      so_oe_ff <= status_ff && cs_lvl_ff;
      so_ff <= !wc_busy;
    end
  end

  assign serial_out = so_ff;
  assign serial_out_oe = so_oe_ff;

  // ---------------- checks ----------------
  sequence cmd_go_s;
    go && kind_prog && prog_en_ff && !wc_busy;
  endsequence

  start_on_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_go_s |=> wc_busy)
    else $error("valid frame did not start internal cycle");

  busy_ignores_a: assert property (@(posedge clk) disable iff (!arst_n)
    go && wc_busy |=> $stable(tgt_addr_ff) && $stable(prog_en_ff))
    else $error("frame acted on during internal cycle");

  disabled_blocks_a: assert property (@(posedge clk) disable iff (!arst_n)
    go && !prog_en_ff && !wc_busy |=> !wc_busy)
    else $error("cycle started while disabled");

  enable_holds_a: assert property (@(posedge clk) disable iff (!arst_n)
    prog_en_ff && !(go && kind == k_dis) |=> prog_en_ff)
    else $error("enable state lost without disable");

  ready_shown_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && status_ff && cs_lvl_ff |=> so_oe_ff && (so_ff == !$past(wc_busy)))
    else $error("data out does not show busy state");

  byte_erased_a: assert property (@(posedge clk) disable iff (!arst_n)
    wc_erase_done && !all_ff |=> mem_ff[tgt_addr_ff] == `SEPP_ERASED)
    else $error("addressed byte not erased");

  byte_written_a: assert property (@(posedge clk) disable iff (!arst_n)
    wc_prog_done && !all_ff |=> mem_ff[tgt_addr_ff] == tgt_data_ff)
    else $error("addressed byte not programmed");

  fill_all_a: assert property (@(posedge clk) disable iff (!arst_n)
    wc_prog_done && all_ff |=> mem_ff[0] == tgt_data_ff && mem_ff[(1<<AW)-1] == tgt_data_ff)
    else $error("fill did not reach every location");

  erase_all_a: assert property (@(posedge clk) disable iff (!arst_n)
    wc_erase_done && all_ff |=> mem_ff[0] == `SEPP_ERASED && mem_ff[1] == `SEPP_ERASED)
    else $error("bulk erase left bits cleared");

  partial_drop_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && pend_ff[1] && !armed_ff && !wc_busy |=> !wc_busy)
    else $error("incomplete frame started a cycle");
endmodule
`default_nettype wire

// ===== test/sepp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sepp_host_model
(
  // lines driven by the host
  output var logic chip_select,
  output var logic serial_clock,
  output var logic serial_in,
  // status line from the device
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  initial
  begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  // clock runs only inside a frame, data shows the inverse of the last bit after it
  task automatic frame(input logic [19:0] bits, input int n);
    int i;
    #7.3;
    chip_select = 1'b1;
    #20;
    for (i = n - 1; i >= 0; i--)
    begin
      serial_in = bits[i];
      #12;
      serial_clock = 1'b1;
      #24;
      serial_clock = 1'b0;
      #12;
    end
    serial_in = ~serial_in;
    #30;
    chip_select = 1'b0;
    #40;
  endtask
  // raise select and watch the status bit until ready
  task automatic poll(output logic seen_busy, output logic ready);
    int k;
    seen_busy = 1'b0;
    ready = 1'b0;
    chip_select = 1'b1;
    for (k = 0; k < 1000 && ready !== 1'b1; k++)
    begin
      #5;
      if (serial_out_oe === 1'b1 && serial_out === 1'b0) seen_busy = 1'b1;
      if (serial_out_oe === 1'b1 && serial_out === 1'b1) ready = 1'b1;
    end
    chip_select = 1'b0;
    #40;
  endtask
endmodule
`default_nettype wire

// ===== test/serial_eeprom_program_protocol_bench.sv
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_program_protocol_bench;
  import sepp_pkg::*;
  localparam int E = 300;
  localparam int P = 300;
  logic clk, arst_n, ce, peek_vld, pk_d1, seen, rdy;
  wire logic chip_select, serial_clock, serial_in;
  logic serial_out, serial_out_oe, program_enable, busy;
  logic [7:0] peek_addr, peek_data, a, d, v;
  logic [19:0] fr;
  logic [31:0] seed;
  int fail_count, num_checks, busy_len;
  int dur_q[$];
  logic [7:0] exp_q[$];

  sepp_engine #(.ERASE_CYC(E), .PROG_CYC(P)) dut_u (.clk(clk), .arst_n(arst_n), .ce(ce),
    .serial_clock(serial_clock), .chip_select(chip_select), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .program_enable(program_enable),
    .busy(busy), .peek_addr(peek_addr), .peek_data(peek_data));
  sepp_host_model host_u (.chip_select(chip_select), .serial_clock(serial_clock),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  always #2.5 clk = ~clk;

  task check(input string what, input logic [31:0] sv, input logic [31:0] ev);
    num_checks++;
    if (sv !== ev)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, ev, sv);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] rnd8();
    for (int i = 0; i < 8; i++)
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  function automatic logic [19:0] f_wr(input logic [7:0] ad, input logic [7:0] dt);
    logic [7:0] r;
    r = rnd8();
    return {1'b1, 2'b01, r[0], ad, dt};
  endfunction

  function automatic logic [19:0] f_ctl(input logic [1:0] sub);
    logic [7:0] r;
    r = rnd8();
    return {8'h00, 1'b1, 2'b00, sub, r[6:0]};
  endfunction

  function automatic logic [19:0] f_er(input logic [7:0] ad);
    logic [7:0] r;
    r = rnd8();
    return {8'h00, 1'b1, 2'b11, r[0], ad};
  endfunction

  task settle;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task wait_ready;
    host_u.poll(seen, rdy);
    check("busy_shown", seen, 1);
    check("ready", rdy, 1);
    if (rdy !== 1'b1)
      close_out;
  endtask

  task peek(input logic [7:0] ad, input logic [7:0] ex);
    @(posedge clk);
    peek_addr <= ad;
    peek_vld <= 1'b1;
    exp_q.push_back(ex);
    @(posedge clk);
    peek_vld <= 1'b0;
  endtask

  task bulk_fill_cmd(input logic [7:0] dt);
    dur_q.push_back(E + P);
    fr = f_ctl(2'b01);
    host_u.frame({fr[11:0], dt}, 20);
  endtask

  // result watcher: content reads and busy lengths
  always @(posedge clk)
  begin
    if (pk_d1 === 1'b1)
      check("peek_data", peek_data, exp_q.pop_front());
    pk_d1 <= peek_vld;
    if (busy === 1'b1)
      busy_len++;
    else
    begin
      if (busy_len > 0)
      begin
        check("busy_len", busy_len >= dur_q[0] && busy_len <= dur_q[0] + 2, 1);
        void'(dur_q.pop_front());
      end
      busy_len = 0;
    end
  end

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    peek_addr = 8'h00;
    peek_vld = 1'b0;
    pk_d1 = 1'b0;
    seed = 32'd83476;
    fail_count = 0;
    num_checks = 0;
    busy_len = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    settle;
    check("program_enable", program_enable, 0);
    check("busy", busy, 0);
    check("serial_out_oe", serial_out_oe, 0);
    // enable, then a first write to a random address
    host_u.frame(f_ctl(2'b11), 12);
    settle;
    check("program_enable", program_enable, 1);
    a = rnd8();
    d = rnd8();
    dur_q.push_back(E + P);
    host_u.frame(f_wr(a, d), 20);
    check("busy", busy, 1);
    wait_ready;
    peek(a, d);
    dur_q.push_back(E);
    host_u.frame(f_ctl(2'b10), 12);
    wait_ready;
    peek(rnd8(), 8'hff);
    peek(a, 8'hff);
    // second fill must not keep zeros of the first
    v = rnd8();
    bulk_fill_cmd(~v);
    wait_ready;
    bulk_fill_cmd(v);
    wait_ready;
    peek(rnd8(), v);
    // disable sent during an erase is ignored
    dur_q.push_back(E);
    host_u.frame(f_er(a), 12);
    host_u.frame(f_ctl(2'b00), 12);
    wait_ready;
    check("program_enable", program_enable, 1);
    peek(a, 8'hff);
    peek(a ^ 8'h01, v);
    // write sent during a fill is ignored
    d = rnd8();
    bulk_fill_cmd(~d);
    host_u.frame(f_wr(a, d), 20);
    wait_ready;
    peek(a, ~d);
    dur_q.push_back(E + P);
    host_u.frame(f_wr(a, d), 20);
    wait_ready;
    peek(a, d);
    host_u.frame(f_wr(a, ~d) >> 8, 12);
    settle;
    check("busy", busy, 0);
    host_u.frame(f_ctl(2'b00), 12);
    settle;
    check("program_enable", program_enable, 0);
    host_u.frame(f_wr(a, ~d), 20);
    settle;
    check("busy", busy, 0);
    peek(a, d);
    settle;
    close_out;
  end
endmodule
`default_nettype wire
